// ### peripheral_gating_cfg.svh
/*
 Register offsets, bit positions, reset values and bus codes for the
 peripheral clock gating bank. Assumes inclusion by bare name.
*/
`ifndef PERIPHERAL_GATING_CFG_SVH
`define PERIPHERAL_GATING_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_GATE_ONE          12'h000
`define OFS_GATE_TWO          12'h004
`define OFS_GATE_THREE        12'h008
`define GATE_RESET            16'h0000
`define GATE_WORDS            3
`define GATE_WIDTH            16

// ---------------------------------------------------------------
// First register bit positions
// ---------------------------------------------------------------
`define TIMER5_OFF_BIT        15
`define TIMER4_OFF_BIT        14
`define TIMER3_OFF_BIT        13
`define TIMER2_OFF_BIT        12
`define TIMER1_OFF_BIT        11
`define ENCODER1_OFF_BIT      10
`define MOTOR_PWM1_OFF_BIT    9
`define TWO_WIRE1_OFF_BIT     7
`define SERIAL2_OFF_BIT       6
`define SERIAL1_OFF_BIT       5
`define SYNC_SERIAL2_OFF_BIT  4
`define SYNC_SERIAL1_OFF_BIT  3
`define CAN_CTRL_OFF_BIT      1
`define CONVERTER1_OFF_BIT    0

// ---------------------------------------------------------------
// Second register bit positions
// ---------------------------------------------------------------
`define CAPTURE8_OFF_BIT      15
`define CAPTURE7_OFF_BIT      14
`define CAPTURE2_OFF_BIT      9
`define CAPTURE1_OFF_BIT      8
`define COMPARE4_OFF_BIT      3
`define COMPARE3_OFF_BIT      2
`define COMPARE2_OFF_BIT      1
`define COMPARE1_OFF_BIT      0

// ---------------------------------------------------------------
// Third register bit positions
// ---------------------------------------------------------------
`define COMPARATOR_OFF_BIT     10
`define CALENDAR_CLOCK_OFF_BIT 9
`define PARALLEL_PORT_OFF_BIT  8
`define CHECKSUM_UNIT_OFF_BIT  7
`define DAC1_OFF_BIT           6
`define ENCODER2_OFF_BIT       5
`define MOTOR_PWM2_OFF_BIT     4

// ---------------------------------------------------------------
// Bus response codes
// ---------------------------------------------------------------
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// ### peripheral_gating_pkg.sv
/*
 Types shared by the peripheral clock gating bank.
 Assumes peripheral_gating_cfg.svh is on the include path.
*/
package peripheral_gating_pkg;
   typedef logic [15:0] gate_word_t;
   typedef enum logic [1:0] {SEL_ONE, SEL_TWO, SEL_THREE, SEL_NONE} sel_t;
endpackage

// ### peripheral_clock_gating_bank.sv
/*
 Peripheral clock gating bank: three software gating registers on an
 AXI4-Lite slave, one glitch-free clock gate per present peripheral.
 Assumes one 200 MHz clock, synchronous active-high reset, and that
 each peripheral qualifies its own register access with its enable.
*/
// Summary of operation
// - First register bits 15..11 turn off timers 5..1; one disables.
// - First register bit 10 turns off encoder 1, bit 9 motor PWM 1.
// - First register bits 7..3 turn off two-wire, serials, sync serials.
// - First register bit 1 turns off CAN, bit 0 converter 1.
// - Unimplemented bits read zero and ignore writes.
// - Second register bits 15,14,9,8 turn off captures 8,7,2,1.
// - Second register bits 3..0 turn off compares 4..1.
// - Third register bits 10,9,8 turn off comparator, calendar, parallel port.
// - Third register bits 7..4 turn off checksum, DAC, encoder 2, PWM 2.
// - Gating bits are read/write and reset to zero.
// - A disabled peripheral gets no clock and its registers are blocked.
// - Disable or enable takes effect one cycle after the bit changes.
// - A peripheral runs only if its bit is zero and it is present.
`timescale 1ns/1ps
`include "peripheral_gating_cfg.svh"

module peripheral_clock_gating_bank
   import peripheral_gating_pkg::*;
#(
   parameter int         ADDR_W        = 12,
   parameter gate_word_t PRESENT_ONE   = 16'hffff,
   parameter gate_word_t PRESENT_TWO   = 16'hffff,
   parameter gate_word_t PRESENT_THREE = 16'hffff
) (
   // Clock and reset
   input  wire logic              MCLK_I,
   input  wire logic              RESET_I,
   // Write address channel
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input  wire logic              S_AXI_AWVALID_I,
   output logic                   S_AXI_AWREADY_O,
   // Write data channel
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   input  wire logic              S_AXI_WVALID_I,
   output logic                   S_AXI_WREADY_O,
   // Write response channel
   output logic [1:0]             S_AXI_BRESP_O,
   output logic                   S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   // Read address channel
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input  wire logic              S_AXI_ARVALID_I,
   output logic                   S_AXI_ARREADY_O,
   // Read data channel
   output logic [31:0]            S_AXI_RDATA_O,
   output logic [1:0]             S_AXI_RRESP_O,
   output logic                   S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I,
   // Peripheral side, bit 16*k+n belongs to register k bit n
   output logic [47:0]            PERIPH_CLK_O,
   output logic [47:0]            PERIPH_EN_O
);

   // ---------------------------------------------------------------
   // Implemented bit masks
   // ---------------------------------------------------------------
   localparam gate_word_t ONE = 16'h0001;
   localparam gate_word_t MASK_ONE =
        (ONE << `TIMER5_OFF_BIT) | (ONE << `TIMER4_OFF_BIT)
      | (ONE << `TIMER3_OFF_BIT) | (ONE << `TIMER2_OFF_BIT)
      | (ONE << `TIMER1_OFF_BIT)
      | (ONE << `ENCODER1_OFF_BIT) | (ONE << `MOTOR_PWM1_OFF_BIT)
      | (ONE << `TWO_WIRE1_OFF_BIT) | (ONE << `SERIAL2_OFF_BIT)
      | (ONE << `SERIAL1_OFF_BIT) | (ONE << `SYNC_SERIAL2_OFF_BIT)
      | (ONE << `SYNC_SERIAL1_OFF_BIT)
      | (ONE << `CAN_CTRL_OFF_BIT) | (ONE << `CONVERTER1_OFF_BIT);
   localparam gate_word_t MASK_TWO =
        (ONE << `CAPTURE8_OFF_BIT) | (ONE << `CAPTURE7_OFF_BIT)
      | (ONE << `CAPTURE2_OFF_BIT) | (ONE << `CAPTURE1_OFF_BIT)
      | (ONE << `COMPARE4_OFF_BIT) | (ONE << `COMPARE3_OFF_BIT)
      | (ONE << `COMPARE2_OFF_BIT) | (ONE << `COMPARE1_OFF_BIT);
   localparam gate_word_t MASK_THREE =
        (ONE << `COMPARATOR_OFF_BIT)
      | (ONE << `CALENDAR_CLOCK_OFF_BIT)
      | (ONE << `PARALLEL_PORT_OFF_BIT)
      | (ONE << `CHECKSUM_UNIT_OFF_BIT) | (ONE << `DAC1_OFF_BIT)
      | (ONE << `ENCODER2_OFF_BIT) | (ONE << `MOTOR_PWM2_OFF_BIT);
   localparam logic [47:0] IMPL  = {MASK_THREE, MASK_TWO, MASK_ONE};
   localparam logic [47:0] AVAIL = IMPL
      & {PRESENT_THREE, PRESENT_TWO, PRESENT_ONE};

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   gate_word_t  gate_one;
   gate_word_t  gate_two;
   gate_word_t  gate_three;
   logic [47:0] gate_flat;
   logic [47:0] en_q;
   logic        wr_take;
   logic        rd_take;
   sel_t        wsel;
   sel_t        rsel;
   gate_word_t  next_word;
   gate_word_t  cur_word;
   gate_word_t  rd_word;

   function automatic sel_t decode(input logic [ADDR_W-1:0] addr);
      unique case (addr)
         `OFS_GATE_ONE:   decode = SEL_ONE;
         `OFS_GATE_TWO:   decode = SEL_TWO;
         `OFS_GATE_THREE: decode = SEL_THREE;
         default:         decode = SEL_NONE;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Write path: address and data taken together
   // ---------------------------------------------------------------
   assign wr_take         = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~S_AXI_BVALID_O;
   assign S_AXI_AWREADY_O = wr_take;
   assign S_AXI_WREADY_O  = wr_take;
   assign wsel            = decode(S_AXI_AWADDR_I);

   always_comb begin
      unique case (wsel)
         SEL_ONE:   cur_word = gate_one;
         SEL_TWO:   cur_word = gate_two;
         SEL_THREE: cur_word = gate_three;
         SEL_NONE:  cur_word = `GATE_RESET;
      endcase
      next_word[15:8] = S_AXI_WSTRB_I[1] ? S_AXI_WDATA_I[15:8] : cur_word[15:8];
      next_word[7:0]  = S_AXI_WSTRB_I[0] ? S_AXI_WDATA_I[7:0] : cur_word[7:0];
   end

   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         gate_one   <= `GATE_RESET;
         gate_two   <= `GATE_RESET;
         gate_three <= `GATE_RESET;
      end else if (wr_take) begin
         if (wsel == SEL_ONE)
            gate_one <= next_word & MASK_ONE;
         if (wsel == SEL_TWO)
            gate_two <= next_word & MASK_TWO;
         if (wsel == SEL_THREE)
            gate_three <= next_word & MASK_THREE;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O  <= `RESP_OKAY;
      end else if (wr_take) begin
         S_AXI_BVALID_O <= 1'b1;
         S_AXI_BRESP_O  <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (S_AXI_BREADY_I) begin
         S_AXI_BVALID_O <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   assign rd_take         = S_AXI_ARVALID_I & ~S_AXI_RVALID_O;
   assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
   assign rsel            = decode(S_AXI_ARADDR_I);

   always_comb begin
      unique case (rsel)
         SEL_ONE:   rd_word = gate_one;
         SEL_TWO:   rd_word = gate_two;
         SEL_THREE: rd_word = gate_three;
         SEL_NONE:  rd_word = `GATE_RESET;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O  <= 32'h0000_0000;
         S_AXI_RRESP_O  <= `RESP_OKAY;
      end else if (rd_take) begin
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O  <= {16'h0000, rd_word};
         S_AXI_RRESP_O  <= (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Enables, one cycle behind the gating bits
   // ---------------------------------------------------------------
   assign gate_flat = {gate_three, gate_two, gate_one};

   always_ff @(posedge MCLK_I) begin
      if (RESET_I)
         en_q <= AVAIL;
      else
         en_q <= ~gate_flat & AVAIL;
   end

   // Peripherals block their own register access while low
   assign PERIPH_EN_O = en_q;

   // ---------------------------------------------------------------
   // Per-peripheral clock gates
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 48; g++) begin : g_gate
         if (AVAIL[g]) begin : g_cell
            logic en_lat;
            always_latch begin
               if (!MCLK_I)
                  en_lat <= en_q[g];
            end
            assign PERIPH_CLK_O[g] = MCLK_I & en_lat;
         end else begin : g_none
            assign PERIPH_CLK_O[g] = 1'b0;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_unimpl_zero;
      @(posedge MCLK_I) disable iff (RESET_I)
      (gate_flat & ~IMPL) == 48'h0;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("Unimplemented gating bit set");

   property p_wr_one;
      @(posedge MCLK_I) disable iff (RESET_I)
      (wr_take && wsel == SEL_ONE && S_AXI_WSTRB_I[1:0] == 2'h3)
      |=> gate_one == ($past(S_AXI_WDATA_I[15:0]) & MASK_ONE);
   endproperty
   a_wr_one: assert property (p_wr_one)
      else $error("First register write not stored");

   property p_wr_two;
      @(posedge MCLK_I) disable iff (RESET_I)
      (wr_take && wsel == SEL_TWO && S_AXI_WSTRB_I[1:0] == 2'h3)
      |=> gate_two == ($past(S_AXI_WDATA_I[15:0]) & MASK_TWO);
   endproperty
   a_wr_two: assert property (p_wr_two)
      else $error("Second register write not stored");

   property p_wr_three;
      @(posedge MCLK_I) disable iff (RESET_I)
      (wr_take && wsel == SEL_THREE && S_AXI_WSTRB_I[1:0] == 2'h3)
      |=> gate_three == ($past(S_AXI_WDATA_I[15:0]) & MASK_THREE);
   endproperty
   a_wr_three: assert property (p_wr_three)
      else $error("Third register write not stored");

   property p_rd_three;
      @(posedge MCLK_I) disable iff (RESET_I)
      (rd_take && rsel == SEL_THREE)
      |=> S_AXI_RVALID_O && S_AXI_RDATA_O == {16'h0000, $past(gate_three)};
   endproperty
   a_rd_three: assert property (p_rd_three)
      else $error("Third register read wrong");

   property p_reset_zero;
      @(posedge MCLK_I) $past(RESET_I) |-> gate_flat == 48'h0;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("Gating bits not cleared by reset");

   property p_delay;
      @(posedge MCLK_I) disable iff (RESET_I)
      $changed(gate_flat) |=> PERIPH_EN_O == (~$past(gate_flat) & AVAIL);
   endproperty
   a_delay: assert property (p_delay)
      else $error("Enable not applied one cycle later");

   property p_absent_off;
      @(posedge MCLK_I) (PERIPH_EN_O & ~AVAIL) == 48'h0;
   endproperty
   a_absent_off: assert property (p_absent_off)
      else $error("Absent peripheral enabled");

   property p_no_clk_absent;
      @(negedge MCLK_I) (PERIPH_CLK_O & ~AVAIL) == 48'h0;
   endproperty
   a_no_clk_absent: assert property (p_no_clk_absent)
      else $error("Clock on absent peripheral");

   property p_off_disabled;
      @(posedge MCLK_I) disable iff (RESET_I)
      gate_one[`TIMER1_OFF_BIT] |=> !PERIPH_EN_O[`TIMER1_OFF_BIT];
   endproperty
   a_off_disabled: assert property (p_off_disabled)
      else $error("Disabled peripheral still enabled");

   c_write:  cover property (@(posedge MCLK_I) wr_take && wsel != SEL_NONE);
   c_bad:    cover property (@(posedge MCLK_I) wr_take && wsel == SEL_NONE);
   c_read:   cover property (@(posedge MCLK_I) rd_take && rsel == SEL_TWO);
   c_toggle: cover property (@(posedge MCLK_I) $fell(PERIPH_EN_O[0]));

endmodule // peripheral_clock_gating_bank

// ### tb_top.sv
/*
 Self-checking bench for the peripheral clock gating bank, with a
 bus master, an integer model of the three gating words and clock checks.
 Assumes the design, its package and its cfg header are compiled first.
*/
`timescale 1ns/1ps
`include "peripheral_gating_cfg.svh"

module tb_top;
   import peripheral_gating_pkg::*;

   // ---------------------------------------------------------------
   // Implemented and present bits
   // ---------------------------------------------------------------
   localparam gate_word_t IMP1 = 16'hfefb;
   localparam gate_word_t IMP2 = 16'hc30f;
   localparam gate_word_t IMP3 = 16'h07f0;
   // Motor PWM 2 left out of this variant
   localparam gate_word_t PR3  = 16'hffef;

   logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [47:0] pclk, pen;
   int          errors, compares, cycles, seed, k, m[3];
   int          hi_cnt[48], lo_cnt[48];

   peripheral_clock_gating_bank #(.PRESENT_THREE(PR3)) dut_u (
      .MCLK_I(mclk), .RESET_I(rst),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .PERIPH_CLK_O(pclk), .PERIPH_EN_O(pen)
   );

   // ---------------------------------------------------------------
   // Model helpers
   // ---------------------------------------------------------------
   function automatic gate_word_t imp(input int i);
      imp = (i == 0) ? IMP1 : (i == 1) ? IMP2 : (i == 2) ? IMP3 : 16'hffff;
   endfunction

   function automatic logic [11:0] ofs(input int i);
      ofs = (i == 0) ? `OFS_GATE_ONE : (i == 1) ? `OFS_GATE_TWO :
            (i == 2) ? `OFS_GATE_THREE : (i == 3) ? 12'h00c : 12'hffc;
   endfunction

   function automatic logic [47:0] en_exp();
      en_exp = {~gate_word_t'(m[2]) & IMP3 & PR3, ~gate_word_t'(m[1]) & IMP2,
                ~gate_word_t'(m[0]) & IMP1};
   endfunction

   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ---------------------------------------------------------------
   // Bus master
   // ---------------------------------------------------------------
   task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
      logic [47:0] old_en;
      old_en = en_exp();
      @(posedge mclk);
      awaddr <= ofs(i);
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(negedge mclk);
      while (!(awready === 1'b1 && wready === 1'b1)) @(negedge mclk);
      @(posedge mclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      if (i < 3) begin
         if (s[0]) m[i][7:0] = d[7:0];
         if (s[1]) m[i][15:8] = d[15:8];
         m[i] = m[i] & imp(i);
      end
      #1 chk("enable before", old_en, pen);
      while (bvalid !== 1'b1) @(negedge mclk);
      chk("bresp", (i < 3) ? `RESP_OKAY : `RESP_SLVERR, bresp);
      @(posedge mclk);
      bready <= 1'b0;
      #1 chk("enable after", en_exp(), pen);
   endtask

   task automatic rd(input int i);
      gate_word_t exp;
      exp = (i < 3) ? gate_word_t'(m[i]) : 16'h0000;
      @(posedge mclk);
      araddr <= ofs(i);
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge mclk);
      while (arready !== 1'b1) @(negedge mclk);
      @(posedge mclk);
      arvalid <= 1'b0;
      #1;
      while (rvalid !== 1'b1) @(negedge mclk);
      chk("rdata", {32'h0, exp}, {16'h0, rdata});
      chk("arready while busy", 48'h0, {47'h0, arready});
      chk("rresp", (i < 3) ? `RESP_OKAY : `RESP_SLVERR, rresp);
      @(posedge mclk);
      rready <= 1'b0;
   endtask

   // Counts high and low phases of every gated clock over eight cycles
   task automatic clk_chk();
      logic [47:0] e;
      e = en_exp();
      for (int i = 0; i < 48; i++) begin
         hi_cnt[i] = 0;
         lo_cnt[i] = 0;
      end
      repeat (8) begin
         @(posedge mclk);
         #1;
         for (int i = 0; i < 48; i++) if (pclk[i] === 1'b1) hi_cnt[i]++;
         @(negedge mclk);
         #1;
         for (int i = 0; i < 48; i++) if (pclk[i] === 1'b0) lo_cnt[i]++;
      end
      for (int i = 0; i < 48; i++) begin
         chk("clock high phases", e[i] ? 48'd8 : 48'd0, 48'(hi_cnt[i]));
         chk("clock low phases", 48'd8, 48'(lo_cnt[i]));
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock and watchdog
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      wstrb = 4'h0;
      seed = 32'h432a953b;
      m = '{0, 0, 0};
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 chk("enable at reset", en_exp(), pen);
      for (int i = 0; i < 3; i++) rd(i);
      clk_chk();
      // Walking one through every bit position
      for (int i = 0; i < 3; i++) begin
         for (int b = 0; b < 16; b++) begin
            wr(i, 32'h1 << b, 4'h3);
            rd(i);
         end
      end
      for (int i = 0; i < 3; i++) wr(i, 32'hffffffff, 4'hf);
      for (int i = 0; i < 3; i++) rd(i);
      clk_chk();
      // Unmapped places leave the model untouched
      for (int i = 3; i < 5; i++) wr(i, 32'h0, 4'hf);
      for (int i = 0; i < 5; i++) rd(i);
      repeat (24) begin
         k = ($random(seed) & 32'h7fffffff) % 3;
         wr(k, $random(seed), 4'($random(seed)));
         rd(k);
      end
      clk_chk();
      // Second reset in mid-run
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      m = '{0, 0, 0};
      @(posedge mclk);
      #1 chk("enable after reset", en_exp(), pen);
      for (int i = 0; i < 3; i++) rd(i);
      final_report();
   end
endmodule // tb_top
